/* File: core/pio_cfg_pkg.sv */
// Constants shared by the parallel port configuration block and its helpers.
// Assumes one 250 MHz clock domain and an 8-bit register port.
package pio_cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Port geometry.
  localparam int PORT_W      = 8;
  localparam int NIB_W       = 4;
  localparam int MAX_PORTS   = 12;
  localparam int PORTS_SMALL = 3;
  localparam int PORTS_LARGE = 12;
  localparam int LINES       = MAX_PORTS * PORT_W;
  localparam int GROUP       = 3;
  localparam int C_SLOT      = 2;
  localparam int SYNC_W      = LINES + 3;
  localparam int SYNC_STROBE = LINES;
  localparam int SYNC_XCLK   = LINES + 1;
  localparam int SYNC_XTRIG  = LINES + 2;

  ////////////////////////////////////////////////////////////////////////////
  // Register port and map.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int IDX_W  = 4;

  localparam logic [3:0] PAGE_SETUP = 4'h0;
  localparam logic [3:0] PAGE_OUT   = 4'h1;
  localparam logic [3:0] PAGE_IN    = 4'h2;

  localparam logic [ADDR_W-1:0] EDGE_ADDR   = 8'h0c;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h30;
  localparam logic [ADDR_W-1:0] COUNT_ADDR  = 8'h31;

  ////////////////////////////////////////////////////////////////////////////
  // Setup value fields.
  localparam int DIR_BIT    = 0;
  localparam int LO_DIR_BIT = 0;
  localparam int HI_DIR_BIT = 1;
  localparam int NIB_FMT_BIT = 2;
  localparam int MODE_LSB   = 1;
  localparam int MODE_MSB   = 2;

  localparam logic [1:0] MODE_BASIC   = 2'b00;
  localparam logic [1:0] MODE_STROBED = 2'b01;

  localparam logic DIR_OUTPUT = 1'b0;
  localparam logic DIR_INPUT  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Edge select and status fields.
  localparam int EDGE_FALL_BIT = 0;
  localparam int ST_STROBED    = 0;
  localparam int ST_WIDE       = 1;
  localparam int ST_XCLK       = 2;
  localparam int ST_XTRIG      = 3;
  localparam int ST_FALLING    = 4;
  localparam int ST_OVERRUN    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [DATA_W-1:0] SETUP_RESET = 8'h01;
  localparam logic [PORT_W-1:0] OUT_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_DATA   = 8'h00;
  localparam logic [DATA_W-1:0] COUNT_ONE   = 8'h01;

endpackage

/* File: core/capture_if.sv */
// Carrier between the configuration core and the strobe capture unit.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface capture_if;
  import pio_cfg_pkg::*;

  logic              strobe_sync;
  logic              edge_falling;
  logic              arm;
  logic [LINES-1:0]  data_sync;
  logic [LINES-1:0]  held;
  logic              captured;

  modport ctrl (
    output strobe_sync,
    output edge_falling,
    output arm,
    output data_sync,
    input  held,
    input  captured
  );

  modport cap (
    input  strobe_sync,
    input  edge_falling,
    input  arm,
    input  data_sync,
    output held,
    output captured
  );
endinterface

/* File: core/pin_sync.sv */
// Two-stage synchroniser bank for asynchronous pins.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ns
module pin_sync
  import pio_cfg_pkg::*;
#(
  parameter int W = SYNC_W
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic         ce,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (ce) begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

/* File: core/strobe_capture.sv */
// Strobe edge detector and input capture register.
// Assumes strobe and data have already been synchronised.
`timescale 1ns/1ns
module strobe_capture
  import pio_cfg_pkg::*;
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic ce,
  capture_if.cap    cap
);

  logic             prev_q;
  logic [LINES-1:0] held_q;
  logic             captured_q;
  logic             active_edge;

  always_comb begin
    if (cap.edge_falling) begin
      active_edge = prev_q & ~cap.strobe_sync;
    end else begin
      active_edge = ~prev_q & cap.strobe_sync;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= cap.strobe_sync;
    end
  end

  // The held value changes only on an active edge while armed.
  always_ff @(posedge clock) begin
    if (reset) begin
      held_q     <= '0;
      captured_q <= 1'b0;
    end else if (ce) begin
      captured_q <= cap.arm & active_edge;
      if (cap.arm && active_edge) begin
        held_q <= cap.data_sync; // RL4 RL5 RL16
      end
    end
  end

  assign cap.held     = held_q;
  assign cap.captured = captured_q;

endmodule

/* File: core/pio_cfg.sv */
// Parallel port direction and mode configuration, top level.
// Assumes a plain register port on the block clock and asynchronous pins.
//
// Function
// RL1: Reset leaves every port basic-mode input.
// RL2: Each port independently input or output.
// RL3: Basic mode: outputs latched, inputs read live.
// RL4: Strobed mode: inputs read captured strobe value.
// RL5: Capture edge rising by default, selectable.
// RL6: One input mode shared by all ports.
// RL7: Mode setups accepted on first two ports.
// RL8: Mode field 00 basic, 01 strobed.
// RL9: Direction bit 0 output, 1 input.
// RL10: Third port splits direction per nibble.
// RL11: Whole-port setup 1 input, 0 output.
// RL12: Strobed mode only on small variant.
// RL13: External clock and trigger fixed inputs.
// RL14: Output latches reset to zero.
// RL15: Three or twelve ports per variant.
// RL16: Captured value holds until next edge.
// RL17: Far side gives clean strobe, stable data.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ns
module pio_cfg
  import pio_cfg_pkg::*;
#(
  parameter bit wide_variant = 1'b0
) (
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [LINES-1:0]  port_in,
  output logic      [LINES-1:0]  port_out,
  output logic      [LINES-1:0]  port_oe,
  input  wire logic              strobe_in,
  input  wire logic              ext_clock_in,
  input  wire logic              ext_trigger_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decoding helpers.

  localparam int ACTIVE_PORTS = wide_variant ? PORTS_LARGE : PORTS_SMALL; // RL15

  function automatic logic port_hit(input logic [ADDR_W-1:0] a,
                                    input logic [3:0]        page);
    port_hit = (a[ADDR_W-1:IDX_W] == page) && (int'(a[IDX_W-1:0]) < ACTIVE_PORTS);
  endfunction

  function automatic logic is_c_slot(input logic [IDX_W-1:0] idx);
    is_c_slot = (int'(idx) % GROUP) == C_SLOT;
  endfunction

  // Lowest line of a port's byte in the flat line vectors.
  function automatic int port_base(input logic [IDX_W-1:0] idx);
    port_base = int'(idx) * PORT_W;
  endfunction

  // Single-register address match.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] target);
    reg_hit = (a == target);
  endfunction

  // Output lines read back their latch, input lines their sampled value.
  function automatic logic [PORT_W-1:0] mix_in(input logic [PORT_W-1:0] outv,
                                               input logic [PORT_W-1:0] oev,
                                               input logic [PORT_W-1:0] inv);
    mix_in = (outv & oev) | (inv & ~oev);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and strobe capture.

  // Port lines, strobe and the two fixed inputs share one synchroniser bank, so
  // every pin reaches the logic with the same two-cycle delay.
  logic [SYNC_W-1:0] sync_w;
  logic [LINES-1:0]  in_live;

  pin_sync #(
    .W (SYNC_W)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .ce       (ce),
    .async_in ({ext_trigger_in, ext_clock_in, strobe_in, port_in}),
    .sync_out (sync_w)
  );

  assign in_live = sync_w[LINES-1:0];

  capture_if cap_bus ();

  logic strobed_q;
  logic edge_fall_q;

  assign cap_bus.strobe_sync  = sync_w[SYNC_STROBE];
  assign cap_bus.edge_falling = edge_fall_q;
  assign cap_bus.arm          = strobed_q;
  assign cap_bus.data_sync    = in_live;

  strobe_capture u_capture (
    .clock (clock),
    .reset (reset),
    .ce    (ce),
    .cap   (cap_bus.cap)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Setup write decoding.

  logic [IDX_W-1:0] widx;
  logic             setup_wr;
  logic             c_port;
  logic             lo_dir;
  logic             hi_dir;
  logic [1:0]       mode_field;
  logic             mode_wr;

  assign widx       = addr[IDX_W-1:0];
  assign setup_wr   = wr && port_hit(addr, PAGE_SETUP);
  assign c_port     = is_c_slot(widx);
  assign mode_field = wdata[MODE_MSB:MODE_LSB];

  always_comb begin
    if (c_port && wdata[NIB_FMT_BIT]) begin
      lo_dir = wdata[LO_DIR_BIT]; // RL10
      hi_dir = wdata[HI_DIR_BIT]; // RL10
    end else begin
      lo_dir = wdata[DIR_BIT]; // RL9 RL11
      hi_dir = wdata[DIR_BIT]; // RL9 RL11
    end
  end

  // Only input setups of the first two ports carry a mode. The wide variant has no
  // strobed mode, so its mode bits are dropped, the capture is never armed and every input stays live.
  assign mode_wr = setup_wr && !c_port && !wide_variant // RL7 RL12
                   && (wdata[DIR_BIT] == DIR_INPUT);

  ////////////////////////////////////////////////////////////////////////////
  // Direction and setup storage.

  logic [LINES-1:0]  oe_q;
  logic [DATA_W-1:0] setup_q [MAX_PORTS];

  always_ff @(posedge clock) begin
    if (reset) begin
      oe_q <= '0; // RL1
    end else if (ce && setup_wr) begin
      oe_q[port_base(widx) +: NIB_W]         <= {NIB_W{lo_dir == DIR_OUTPUT}}; // RL2 RL9
      oe_q[port_base(widx) + NIB_W +: NIB_W] <= {NIB_W{hi_dir == DIR_OUTPUT}}; // RL2 RL10
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < MAX_PORTS; i++) begin
        setup_q[i] <= SETUP_RESET; // RL1
      end
    end else if (ce && setup_wr) begin
      // The raw byte is kept, so readback shows mode bits even when they were dropped.
      setup_q[widx] <= wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared input mode and strobe edge.

  always_ff @(posedge clock) begin
    if (reset) begin
      strobed_q <= 1'b0; // RL1
    end else if (ce && mode_wr) begin
      if (mode_field == MODE_STROBED) begin
        strobed_q <= 1'b1; // RL6 RL8
      end else if (mode_field == MODE_BASIC) begin
        strobed_q <= 1'b0; // RL6 RL8
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      edge_fall_q <= 1'b0; // RL5
    end else if (ce && wr && reg_hit(addr, EDGE_ADDR)) begin
      edge_fall_q <= wdata[EDGE_FALL_BIT]; // RL5
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output latches.

  logic [LINES-1:0] out_q;
  logic             out_wr;

  assign out_wr = wr && port_hit(addr, PAGE_OUT);

  // Latches keep their value whatever the direction, so a port turned to output
  // drives the last value written to it.
  always_ff @(posedge clock) begin
    if (reset) begin
      out_q <= '0; // RL14
    end else if (ce && out_wr) begin
      out_q[port_base(widx) +: PORT_W] <= wdata; // RL3
    end
  end

  assign port_out = out_q;
  assign port_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Capture bookkeeping: count and overrun.

  logic             in_rd;
  logic             overrun_q;
  logic             pending_q;
  logic [DATA_W-1:0] count_q;

  assign in_rd = rd && port_hit(addr, PAGE_IN);

  // A second capture before the port is read marks an overrun, so software can tell
  // that one strobed value was lost.
  // A capture in the same cycle as the read wins over the clear.
  always_ff @(posedge clock) begin
    if (reset) begin
      pending_q <= 1'b0;
      overrun_q <= 1'b0;
    end else if (ce) begin
      if (cap_bus.captured) begin
        pending_q <= 1'b1;
        if (pending_q && !in_rd) begin
          overrun_q <= 1'b1;
        end
      end else if (in_rd) begin
        pending_q <= 1'b0;
      end
      if (rd && reg_hit(addr, STATUS_ADDR) && !(cap_bus.captured && pending_q && !in_rd)) begin
        overrun_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= ZERO_DATA;
    end else if (ce && cap_bus.captured) begin
      count_q <= count_q + COUNT_ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [DATA_W-1:0] rd_d;
  logic [DATA_W-1:0] rdata_q;
  logic [PORT_W-1:0] in_view;
  logic [PORT_W-1:0] oe_view;
  logic [PORT_W-1:0] out_view;

  always_comb begin
    oe_view  = oe_q[port_base(widx) +: PORT_W];
    out_view = out_q[port_base(widx) +: PORT_W];
    if (strobed_q) begin
      in_view = cap_bus.held[port_base(widx) +: PORT_W]; // RL4 RL16
    end else begin
      in_view = in_live[port_base(widx) +: PORT_W]; // RL3
    end
  end

  always_comb begin
    rd_d = ZERO_DATA;
    if (port_hit(addr, PAGE_SETUP)) begin
      rd_d = setup_q[widx];
    end else if (port_hit(addr, PAGE_OUT)) begin
      rd_d = out_view;
    end else if (port_hit(addr, PAGE_IN)) begin
      rd_d = mix_in(out_view, oe_view, in_view);
    end else if (reg_hit(addr, EDGE_ADDR)) begin
      rd_d[EDGE_FALL_BIT] = edge_fall_q;
    end else if (reg_hit(addr, STATUS_ADDR)) begin
      rd_d[ST_STROBED] = strobed_q;
      rd_d[ST_WIDE]    = wide_variant;
      // The fixed inputs have no direction bit anywhere in the map.
      rd_d[ST_XCLK]    = sync_w[SYNC_XCLK];  // RL13
      rd_d[ST_XTRIG]   = sync_w[SYNC_XTRIG]; // RL13
      rd_d[ST_FALLING] = edge_fall_q;
      rd_d[ST_OVERRUN] = overrun_q;
    end else if (reg_hit(addr, COUNT_ADDR)) begin
      rd_d = count_q;
    end
  end

  // Read data is registered, so it stands from the edge after the strobe until
  // the next read is taken.
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= ZERO_DATA;
    end else if (ce && rd) begin
      rdata_q <= rd_d;
    end
  end

  assign rdata = rdata_q;

endmodule

/* File: verif/pio_cfg_checker_assertions.sv */
// Checker on the parallel port block's top ports.
// Assumes one clock, synchronous reset and the hand-over register map.
`timescale 1ns/1ns
module pio_cfg_checker
  import pio_cfg_pkg::*;
#(
  parameter bit wide_variant = 1'b0
) (
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic              wr,
  input wire logic              rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic [LINES-1:0]  port_out,
  input wire logic [LINES-1:0]  port_oe
);
  wire w = wr && ce;
  wire r = rd && ce;

  default clocking @(posedge clock);
  endclocking
  default disable iff (reset);

  ////////////////////////////////
  a_reset_clear: assert property (disable iff (1'b0)
    reset && ce |=> !port_oe && !port_out) else $error("lines not cleared");
  a_out_latch: assert property (w && addr == 8'h10 |=> port_out[7:0] == $past(wdata))
    else $error("latch missed write");
  a_dir_decode: assert property (w && addr == 8'h00
    |=> port_oe[7:0] == {8{~$past(wdata[0])}}) else $error("direction misread");
  a_nibble_dir: assert property (w && addr == 8'h02 && wdata[2]
    |=> port_oe[23:16] == {{4{~$past(wdata[1])}}, {4{~$past(wdata[0])}}})
    else $error("nibble direction misread");
  a_oe_hold: assert property (!w |=> $stable(port_oe))
    else $error("direction moved unasked");
  a_rdata_hold: assert property (!r |=> $stable(rdata))
    else $error("read data moved unasked");
  a_out_read: assert property (r && addr == 8'h10 |=> rdata == $past(port_out[7:0]))
    else $error("latch readback wrong");
  a_unmapped: assert property (r && (addr == 8'hff || !wide_variant && addr == 8'h03)
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_variant_bit: assert property (r && addr == 8'h30 |=> rdata[1] == wide_variant)
    else $error("variant flag wrong");
  a_spare_out: assert property (w && addr == 8'h13 && !wide_variant |=> $stable(port_out))
    else $error("absent port written");
endmodule

bind pio_cfg pio_cfg_checker #(.wide_variant(wide_variant)) u_pio_cfg_checker (
  .clock, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata, .port_out, .port_oe
);

/* File: verif/pio_lines_model.sv */
// Far side: input lines, strobe source and the two fixed inputs.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ns
module pio_lines_model
  import pio_cfg_pkg::*;
(
  input  wire logic             clock,
  output logic      [LINES-1:0] port_in,
  output logic                  strobe_in,
  output logic                  ext_clock_in,
  output logic                  ext_trigger_in
);
  initial begin
    port_in = '0;
    strobe_in = 1'b0;
    ext_clock_in = 1'b0;
    ext_trigger_in = 1'b0;
  end

  task automatic set_lines(input logic [LINES-1:0] v);
    @(posedge clock);
    port_in <= v;
  endtask

  // Data stays still three cycles either side of each strobe edge.
  task automatic pulse(input logic [LINES-1:0] d_rise, input logic [LINES-1:0] d_fall);
    set_lines(d_rise);
    repeat (3) @(posedge clock);
    strobe_in <= 1'b1;
    repeat (3) @(posedge clock);
    port_in <= d_fall;
    repeat (3) @(posedge clock);
    strobe_in <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  task automatic set_ext(input logic c, input logic t);
    @(posedge clock);
    ext_clock_in <= c;
    ext_trigger_in <= t;
  endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the parallel port configuration block.
// Assumes the small variant and a 250 MHz clock.
`timescale 1ns/1ns
module tb
  import pio_cfg_pkg::*;
;
  logic              clock;
  logic              reset;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic              ce;
  logic [DATA_W-1:0] rdata;
  logic [LINES-1:0]  port_in, port_out, port_oe;
  logic              strobe_in, ext_clock_in, ext_trigger_in;
  logic [31:0]       seed;
  logic [7:0]        v, d;
  logic [23:0]       a, b;
  int                n_errors = 0;
  int                total_checks = 0;
  int                cycles = 0;

  pio_cfg #(.wide_variant(1'b0)) u_pio_cfg (
    .clock, .reset, .ce, .addr, .wdata, .wr, .rd, .rdata, .port_in,
    .port_out, .port_oe, .strobe_in, .ext_clock_in, .ext_trigger_in
  );
  pio_lines_model u_pio_lines_model (
    .clock, .port_in, .strobe_in, .ext_clock_in, .ext_trigger_in
  );

  ////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] oe_of(input logic [7:0] s, input logic nib);
    if (nib && s[2]) return {{4{~s[1]}}, {4{~s[0]}}};
    return {8{~s[0]}};
  endfunction

  task automatic wr_reg(input logic [7:0] a8, input logic [7:0] d8);
    @(posedge clock);
    addr <= a8;
    wdata <= d8;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a8, input logic [7:0] e);
    @(posedge clock);
    addr <= a8;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    total_checks++;
    if (rdata !== e) begin
      n_errors++;
      $display("Error at %0t: read %h gave %h, want %h", $time, a8, rdata, e);
    end
  endtask

  task automatic chk_pin(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: lines %h, want %h", $time, g, e);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    ce = 1'b1;
    seed = 32'h2c4b;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 3; i++) chk_reg(8'(i), 8'h01);
    chk_pin(port_oe[23:0] | port_out[23:0], 24'h0);
    chk_reg(8'h30, 8'h00);
    $display("reset test done");
    for (int k = 0; k < 8; k++) begin
      for (int i = 0; i < 3; i++) begin
        seed = xs(seed);
        v = (i == 2) ? {5'h0, seed[2:0]} : {7'h0, seed[0]};
        a[i*8 +: 8] = oe_of(v, i == 2);
        b[i*8 +: 8] = seed[15:8];
        wr_reg(8'(i), v);
        wr_reg(8'h10 + 8'(i), seed[15:8]);
      end
      #1;
      chk_pin(port_oe[23:0], a);
      chk_pin(port_out[23:0], b);
    end
    wr_reg(8'h02, 8'h06);
    #1;
    chk_pin({16'h0, port_oe[23:16]}, 24'h0f);
    wr_reg(8'h03, 8'h00);
    wr_reg(8'h13, 8'hff);
    chk_reg(8'h03, 8'h00);
    chk_reg(8'hff, 8'h00);
    $display("direction test done");
    for (int i = 0; i < 3; i++) wr_reg(8'(i), 8'h01);
    seed = xs(seed);
    u_pio_lines_model.set_lines({3{seed}});
    repeat (3) @(posedge clock);
    chk_reg(8'h22, seed[23:16]);
    wr_reg(8'h02, 8'h03);
    wr_reg(8'h00, 8'h05);
    chk_reg(8'h30, 8'h00);
    wr_reg(8'h01, 8'h03);
    chk_reg(8'h30, 8'h01);
    seed = xs(seed);
    d = seed[7:0];
    u_pio_lines_model.pulse({12{d}}, {12{~d}});
    chk_reg(8'h20, d);
    repeat (4) @(posedge clock);
    chk_reg(8'h20, d);
    wr_reg(EDGE_ADDR, 8'h01);
    chk_reg(8'h30, 8'h11);
    seed = xs(seed);
    d = seed[7:0];
    u_pio_lines_model.pulse({12{d}}, {12{~d}});
    chk_reg(8'h20, ~d);
    wr_reg(8'h00, 8'h01);
    chk_reg(8'h30, 8'h10);
    u_pio_lines_model.set_ext(1'b1, 1'b1);
    repeat (3) @(posedge clock);
    chk_reg(8'h30, 8'h1c);
    $display("mode test done");
    wr_reg(8'h00, 8'h03);
    seed = xs(seed);
    d = seed[7:0];
    u_pio_lines_model.pulse({12{seed[15:8]}}, {12{~seed[15:8]}});
    u_pio_lines_model.pulse({12{d}}, {12{~d}});
    chk_reg(8'h30, 8'h3d);
    wr_reg(8'h01, 8'h00);
    wr_reg(8'h11, seed[23:16]);
    chk_reg(8'h21, seed[23:16]);
    chk_reg(8'h30, 8'h1d);
    chk_reg(8'h20, ~d);
    chk_reg(8'h31, 8'h04);
    @(posedge clock);
    ce <= 1'b0;
    wr_reg(8'h10, ~b[7:0]);
    @(posedge clock);
    ce <= 1'b1;
    chk_reg(8'h10, b[7:0]);
    chk_pin({16'h0, port_out[7:0]}, {16'h0, b[7:0]});
    $display("capture test done");
    print_verdict();
  end
endmodule
